// ===== common/tpsr_cfg.svh
// timing and geometry constants for the two-phase static ram cycle
// assumes a 10 mhz system clock on both ends
`ifndef TPSR_CFG_SVH
`define TPSR_CFG_SVH
`define TPSR_CLK_NS 100
`define TPSR_ROWS 16
`define TPSR_COLS 32
`define TPSR_WORDS 512
`define TPSR_ADDR_W 9
`define TPSR_ROW_W 4
`define TPSR_COL_W 5
`define TPSR_SETUP_NS 200
`define TPSR_SETUP_CYC ((`TPSR_SETUP_NS + `TPSR_CLK_NS - 1) / `TPSR_CLK_NS)
`define TPSR_GAP12_NS 280
`define TPSR_GAP12_CYC ((`TPSR_GAP12_NS + `TPSR_CLK_NS - 1) / `TPSR_CLK_NS)
`define TPSR_OUTDLY_NS 440
`define TPSR_OUTDLY_CYC ((`TPSR_OUTDLY_NS + `TPSR_CLK_NS - 1) / `TPSR_CLK_NS)
`define TPSR_GAP21_NS 60
`define TPSR_GAP21_CYC ((`TPSR_GAP21_NS + `TPSR_CLK_NS - 1) / `TPSR_CLK_NS)
`define TPSR_HOLD_CYC 20
`endif

// ===== common/tpsr_pkg.sv
// types shared by both ends of the two-phase static ram cycle
// assumes tpsr_cfg.svh is available on the include path
package tpsr_pkg;
  typedef enum logic [1:0]
  {
    TPSR_DESEL = 2'b00,
    TPSR_READ = 2'b01,
    TPSR_WRITE = 2'b10
  } tpsr_kind_e;
endpackage

// ===== common/tpsr_if.sv
// link between the ram device and its memory controller
// wired-or data line: low if any enabled driver pulls low, else pulled up
`timescale 1ns/10ps
`include "tpsr_cfg.svh"
interface tpsr_if;
  logic phase1_n;
  logic phase2_n;
  logic [`TPSR_ADDR_W-1:0] cell_address;
  logic dev_sel_n;
  logic write_sel;
  logic dev_data_oe;
  logic ctl_data_o;
  logic ctl_data_oe;
  wire data_line;
  // device only ever drives zero; controller drives its bit
  assign data_line = dev_data_oe ? 1'b0 :
                     (ctl_data_oe ? ctl_data_o : 1'b1);
  modport device
  (
    input phase1_n, phase2_n, cell_address, dev_sel_n, write_sel,
    input data_line,
    output dev_data_oe
  );
  modport ctrl
  (
    output phase1_n, phase2_n, cell_address, dev_sel_n, write_sel,
    output ctl_data_o, ctl_data_oe,
    input data_line
  );
endinterface

// ===== rtl/tpsr_device.sv
// What this block does
// RULE1: 512 one-bit cells, 16 rows by 32 columns
// RULE2: cycle starts phase1 fall; line pulled low
// RULE3: controller sets address 200 ns before phase1 rise
// RULE4: controller sets selects before phase1 rise
// RULE5: phase2 falls at least 280 ns after phase1
// RULE6: selects sampled at phase1 rise
// RULE7: deselected: driver off after phase1
// RULE8: selected, write low: read, driver stays on
// RULE9: selected, write high: write cycle
// RULE10: read bit on line in phase2, 440 ns
// RULE11: one releases line, zero keeps it low
// RULE12: read level held some time after phase2
// RULE13: controller write driver off during reads
// RULE14: write: driver off, line level stored
// RULE15: controller drives write bit through phase2
// RULE16: next phase1 fall 60 ns after phase2 rise
// RULE17: contents held without refresh
// RULE18: controller latches read data when needed
//
// ram device end; phases are sampled on clk_i, so edges are seen one
// clock late. storage has no reset: contents are static.
// assumes the controller holds address and selects steady from the
// start of phase1 until the next cycle, and an external pull-up on
// the shared data line so a released line reads as one.
`timescale 1ns/10ps
`include "tpsr_cfg.svh"
module tpsr_device
  import tpsr_pkg::*;
#(
  parameter int HOLD_CYC = `TPSR_HOLD_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // link
  tpsr_if.device link,
  // user side: observation of the cycle
  output logic [1:0] cycle_kind_o,
  output logic busy_o
);
  // --------------------------------------------------------------
  // edge detection and address capture
  // --------------------------------------------------------------
  logic p1_q;
  logic p2_q;
  logic [`TPSR_ADDR_W-1:0] addr_q;
  tpsr_kind_e kind;
  logic oe;
  logic sensed;
  // hold counter stands in for gate charge that leaks after phase2
  // ends; its width limits the hold to 255 clocks
  logic [7:0] hold_cnt;
  logic [`TPSR_COLS-1:0] cells [`TPSR_ROWS];
  wire p1_fall = p1_q & ~link.phase1_n;
  wire p1_rise = ~p1_q & link.phase1_n;
  wire p2_fall = p2_q & ~link.phase2_n;
  wire p2_rise = ~p2_q & link.phase2_n;
  wire [`TPSR_ROW_W-1:0] row_sel = addr_q[`TPSR_ADDR_W-1:`TPSR_COL_W]; // [RULE1]
  wire [`TPSR_COL_W-1:0] col_sel = addr_q[`TPSR_COL_W-1:0]; // [RULE1]
  wire cell_bit = cells[row_sel][col_sel];

  // --------------------------------------------------------------
  // cycle decode
  // --------------------------------------------------------------
  // chip select is active low; write select only counts when selected
  function automatic tpsr_kind_e decode_kind(input logic sel_n,
                                             input logic wsel);
    tpsr_kind_e k;
    k = TPSR_DESEL;
    if (!sel_n)
      k = wsel ? TPSR_WRITE : TPSR_READ;
    return k;
  endfunction

  wire [1:0] next_kind =
    decode_kind(link.dev_sel_n, link.write_sel); // [RULE6] [RULE8] [RULE9]
  wire in_p2 = ~link.phase2_n;
  wire is_read = (kind == TPSR_READ);
  wire is_write = (kind == TPSR_WRITE);
  // the last count of the hold window is where the driver lets go
  wire hold_last = (hold_cnt == 8'h01);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      p1_q <= 1'b1;
      p2_q <= 1'b1;
      addr_q <= '0;
    end
    else
    begin
      p1_q <= link.phase1_n;
      p2_q <= link.phase2_n;
      if (p1_rise)
        addr_q <= link.cell_address;
    end
  end

  // --------------------------------------------------------------
  // cycle kind register
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      kind <= TPSR_DESEL;
    else if (p1_rise)
      kind <= tpsr_kind_e'(next_kind); // [RULE6]
  end

  // --------------------------------------------------------------
  // read sensing and hold window
  // --------------------------------------------------------------
  // sensed bit is captured on every clock of a read cycle's phase2 so the level survives
  // the phase2 rise, mimicking the held gate charge
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sensed <= 1'b1;
    else if (kind == TPSR_READ && in_p2)
      sensed <= cell_bit; // [RULE10]
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      hold_cnt <= '0;
    else if (p2_rise && kind == TPSR_READ)
      hold_cnt <= 8'(HOLD_CYC); // [RULE12]
    else if (p1_fall)
      hold_cnt <= '0;
    else if (hold_cnt != '0)
      hold_cnt <= hold_cnt - 8'h01;
  end

  // --------------------------------------------------------------
  // data-line driver
  // --------------------------------------------------------------
  // a read keeps the driver on from precharge into phase2; expiry is
  // tested before the hold so the line is let go once charge is gone
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      oe <= 1'b0;
    else if (!link.phase1_n)
      oe <= 1'b1; // [RULE2]
    else if (p1_rise)
      oe <= (next_kind == TPSR_READ); // [RULE7] [RULE8] [RULE14]
    else if (is_read && in_p2)
      oe <= ~cell_bit; // [RULE11]
    else if (is_read && hold_last)
      oe <= 1'b0; // [RULE12]
    else if (is_read && hold_cnt != '0)
      oe <= ~sensed; // [RULE12]
    else if (is_read && link.phase2_n && !p2_q)
      oe <= ~sensed; // [RULE12]
  end

  // --------------------------------------------------------------
  // storage: static, no refresh ever needed
  // --------------------------------------------------------------
  // one write enable per row keeps the decode next to its row
  generate
    for (genvar r = 0; r < `TPSR_ROWS; r++)
    begin : g_row
      wire row_wr = is_write && in_p2 && (row_sel == `TPSR_ROW_W'(r));
      always_ff @(posedge clk_i)
      begin
        if (row_wr)
          cells[r][col_sel] <= link.data_line; // [RULE14] [RULE17]
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // link driver and observation outputs
  // --------------------------------------------------------------
  assign link.dev_data_oe = oe;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cycle_kind_o <= 2'h0;
      busy_o <= 1'b0;
    end
    else
    begin
      cycle_kind_o <= kind;
      busy_o <= ~link.phase1_n | ~link.phase2_n;
    end
  end
endmodule

// ===== rtl/tpsr_ctrl.sv
// memory controller end: generates the two phases and strobes
// assumes one device on the link and an external pull-up on data
`timescale 1ns/10ps
`include "tpsr_cfg.svh"
module tpsr_ctrl
  import tpsr_pkg::*;
#(
  parameter int SETUP_CYC = `TPSR_SETUP_CYC,
  parameter int GAP12_CYC = `TPSR_GAP12_CYC,
  parameter int OUTDLY_CYC = `TPSR_OUTDLY_CYC,
  parameter int GAP21_CYC = `TPSR_GAP21_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // link
  tpsr_if.ctrl link,
  // user request
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_sel_i,
  input wire logic [`TPSR_ADDR_W-1:0] req_addr_i,
  input wire logic req_data_i,
  // user answer
  output logic busy_o,
  output logic done_o,
  output logic rd_data_o
);
  typedef enum logic [2:0]
  {
    TPSR_IDLE = 3'b000,
    TPSR_P1 = 3'b001,
    TPSR_GAP = 3'b010,
    TPSR_P2 = 3'b011,
    TPSR_REST = 3'b100
  } tpsr_cst_e;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  tpsr_cst_e st;
  logic [3:0] cnt;
  logic p1_n, p2_n, sel_n, wsel, dout, doe;
  logic [`TPSR_ADDR_W-1:0] addr;
  wire cnt_done = (cnt == 4'h0);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st <= TPSR_IDLE;
      cnt <= 4'h0;
      p1_n <= 1'b1;
      p2_n <= 1'b1;
      sel_n <= 1'b1;
      wsel <= 1'b0;
      dout <= 1'b0;
      doe <= 1'b0;
      addr <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rd_data_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (!cnt_done)
        cnt <= cnt - 4'h1;
      case (st)
        TPSR_IDLE:
        begin
          if (req_i)
          begin
            addr <= req_addr_i; // [RULE3]
            sel_n <= ~req_sel_i; // [RULE4]
            wsel <= req_write_i; // [RULE4]
            dout <= req_data_i;
            p1_n <= 1'b0;
            busy_o <= 1'b1;
            cnt <= 4'(SETUP_CYC - 1);
            st <= TPSR_P1;
          end
        end
        TPSR_P1:
        begin
          if (cnt_done)
          begin
            p1_n <= 1'b1; // [RULE3] [RULE4]
            doe <= wsel & ~sel_n; // [RULE13] [RULE15]
            cnt <= 4'(GAP12_CYC - 1);
            st <= TPSR_GAP;
          end
        end
        TPSR_GAP:
        begin
          if (cnt_done)
          begin
            p2_n <= 1'b0; // [RULE5]
            cnt <= 4'(OUTDLY_CYC);
            st <= TPSR_P2;
          end
        end
        TPSR_P2:
        begin
          if (cnt_done)
          begin
            if (!wsel)
              rd_data_o <= link.data_line; // [RULE10] [RULE18]
            p2_n <= 1'b1;
            doe <= 1'b0;
            cnt <= 4'(GAP21_CYC - 1);
            st <= TPSR_REST;
          end
        end
        TPSR_REST:
        begin
          if (cnt_done)
          begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            st <= TPSR_IDLE; // [RULE16]
          end
        end
        default:
          st <= TPSR_IDLE;
      endcase
    end
  end

  assign link.phase1_n = p1_n;
  assign link.phase2_n = p2_n;
  assign link.cell_address = addr;
  assign link.dev_sel_n = sel_n;
  assign link.write_sel = wsel;
  assign link.ctl_data_o = dout;
  assign link.ctl_data_oe = doe;
endmodule

// ===== test/tpsr_monitor.sv
// assertions on the link between the ram device and its controller
// assumes both ends share clk_i and arst_n_i
`timescale 1ns/10ps
`include "tpsr_cfg.svh"
module tpsr_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // link
  input wire logic phase1_n,
  input wire logic phase2_n,
  input wire logic [`TPSR_ADDR_W-1:0] cell_address,
  input wire logic dev_sel_n,
  input wire logic write_sel,
  input wire logic dev_data_oe,
  input wire logic ctl_data_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ----------
  // properties
  // ----------
  // device reacts a clock late, so its checks start after the edge, except p_read, which starts on it
  property p_pre; $fell(phase1_n) |=> dev_data_oe; endproperty
  property p_gap; $rose(phase1_n) |-> phase2_n [*3]; endproperty
  property p_addr;
    $rose(phase1_n) |-> cell_address == $past(cell_address, 2);
  endproperty
  property p_sel;
    $rose(phase1_n) |-> dev_sel_n == $past(dev_sel_n, 2)
      && write_sel == $past(write_sel, 2);
  endproperty
  property p_desel;
    $rose(phase1_n) && dev_sel_n |-> ##2 !dev_data_oe [*4];
  endproperty
  property p_read;
    $rose(phase1_n) && !dev_sel_n && !write_sel |-> dev_data_oe [*4];
  endproperty
  property p_wr;
    $rose(phase1_n) && !dev_sel_n && write_sel
      |-> ##2 !dev_data_oe && ctl_data_oe;
  endproperty
  property p_rdoff; !phase2_n && !write_sel |-> !ctl_data_oe; endproperty
  property p_wrhold;
    !phase2_n && !dev_sel_n && write_sel |-> ctl_data_oe;
  endproperty
  property p_rest; $rose(phase2_n) |=> phase1_n; endproperty
  a_pre: assert property (p_pre) else $error("no precharge");
  a_gap: assert property (p_gap) else $error("phase gap short");
  a_addr: assert property (p_addr) else $error("addr setup");
  a_sel: assert property (p_sel) else $error("select setup");
  a_desel: assert property (p_desel) else $error("desel drive");
  a_read: assert property (p_read) else $error("read drive");
  a_wr: assert property (p_wr) else $error("write drive");
  a_rdoff: assert property (p_rdoff) else $error("ctl on");
  a_wrhold: assert property (p_wrhold) else $error("ctl off");
  a_rest: assert property (p_rest) else $error("phase1 early");
  c_read: cover property ($rose(phase1_n) && !dev_sel_n && !write_sel);
  c_write: cover property ($rose(phase1_n) && !dev_sel_n && write_sel);
  c_desel: cover property ($rose(phase1_n) && dev_sel_n);
endmodule

// ===== test/two_phase_static_ram_cycle_tb.sv
// self-checking bench: controller and device joined by the link
// assumes package, config header and interface are compiled first
`timescale 1ns/10ps
`include "tpsr_cfg.svh"
module two_phase_static_ram_cycle_tb
  import tpsr_pkg::*;
;
  logic clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic req_i = 1'h0;
  logic req_write_i = 1'h0;
  logic req_sel_i = 1'h0;
  logic req_data_i = 1'h0;
  logic [8:0] req_addr_i = 9'h000;
  logic busy_o;
  logic done_o;
  logic rd_data_o;
  logic dev_busy;
  logic [1:0] kind;
  logic [3:0] exp_q[$];
  logic [3:0] note;
  logic mem_m [512];
  logic [8:0] addrs [12];
  logic d;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  // ---------
  // instances
  // ---------
  tpsr_if link();
  tpsr_ctrl i_tpsr_ctrl (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .link(link), .req_i(req_i), .req_write_i(req_write_i),
    .req_sel_i(req_sel_i), .req_addr_i(req_addr_i),
    .req_data_i(req_data_i), .busy_o(busy_o), .done_o(done_o),
    .rd_data_o(rd_data_o));
  tpsr_device #(.HOLD_CYC(2)) i_tpsr_device (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .link(link), .cycle_kind_o(kind),
    .busy_o(dev_busy));
  tpsr_monitor i_tpsr_monitor (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .phase1_n(link.phase1_n), .phase2_n(link.phase2_n),
    .cell_address(link.cell_address), .dev_sel_n(link.dev_sel_n),
    .write_sel(link.write_sel), .dev_data_oe(link.dev_data_oe),
    .ctl_data_oe(link.ctl_data_oe));
  always #50 clk_i = ~clk_i;
  // --------
  // checking
  // --------
  task tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // note: {data checked, cycle kind, expected bit}
  always @(posedge clk_i)
    if (done_o === 1'b1)
    begin
      note = exp_q.pop_front();
      checks_done++;
      if (kind !== note[2:1])
      begin
        $display("[FAIL] kind exp %0d got %0d", note[2:1], kind);
        failures++;
      end
      if (dev_busy !== 1'b0)
      begin
        $display("[FAIL] dev_busy exp 0 got %0d", dev_busy);
        failures++;
      end
      if (note[3] && rd_data_o !== note[0])
      begin
        $display("[FAIL] rd_data exp %0d got %0d", note[0], rd_data_o);
        failures++;
      end
    end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  // --------
  // stimulus
  // --------
  task op(input logic w, s, input logic [8:0] a, input logic x,
          input logic [3:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge clk_i);
    req_i <= 1'h1;
    req_write_i <= w;
    req_sel_i <= s;
    req_addr_i <= a;
    req_data_i <= x;
    @(posedge clk_i);
    req_i <= 1'h0;
    n = 0;
    // busy rises on the same clock that the request is taken
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while ((busy_o !== 1'b0 || n < 3) && n < 40);
  endtask
  initial
  begin
    void'($urandom(13310));
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'h1;
    foreach (addrs[i])
    begin
      addrs[i] = (i < 4) ? {{4{i[1]}}, {5{i[0]}}} : 9'($urandom);
      d = 1'($urandom);
      mem_m[addrs[i]] = d;
      op(1'h1, 1'h0 == 1'h0, addrs[i], d, {1'b0, TPSR_WRITE, d});
    end
    foreach (addrs[i])
      op(1'h0, 1'h1, addrs[i], 1'h0, {1'b1, TPSR_READ, mem_m[addrs[i]]});
    d = ~mem_m[addrs[0]];
    op(1'h1, 1'h0, addrs[0], d, {1'b0, TPSR_DESEL, 1'b0});
    op(1'h0, 1'h1, addrs[0], 1'h0, {1'b1, TPSR_READ, ~d});
    op(1'h0, 1'h0, addrs[1], 1'h0, {1'b1, TPSR_DESEL, 1'b1});
    repeat (5) @(posedge clk_i);
    tally_and_finish();
  end
endmodule
